// [ctpc_bank.sv]
// Chip transfer, power-down pin gating and B pin function control bank.
// Assumes the serial control port decodes into same-clock strobes and
// that the power-down and B pins arrive asynchronously.
`include "ctpc_map.svh"

// Operation
// - Transfer loads mixer phases when update mode set
// - Transfer also applies staged filter coefficients
// - Transfer bit reads one until copy completes
// - Transfer copies staged coefficients always, staged phases only in update mode
// - Local disable bit makes pin ignored
// - Asserted pin overrides channel power modes
// - Field 00: pin forces full power-down
// - Field 01: pin forces standby
// - Field 10: pin ignored entirely
// - B function 000 fast detect, 001 LMFC
// - B function 110 uses secondary field
// - B function 111 input with pull-down
// - Secondary codes: input, transfer, trigger out/in
module ctpc_bank (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire ctpc_pkg::ctpc_req_type  reg_req,
  output logic [7:0]                   reg_rdata,
  output logic                         reg_rvalid,
  input  wire logic                    powerdown_standby_pin,
  input  wire ctpc_pkg::ctpc_pwr_type  chan_power_mode,
  output ctpc_pkg::ctpc_pwr_type       chip_power_state,
  input  wire logic                    phase_update_mode,
  input  wire ctpc_pkg::ctpc_phase_type staged_phase,
  output ctpc_pkg::ctpc_phase_type     active_phase,
  input  wire logic [15:0]             staged_coef,
  output logic [15:0]                  active_coef,
  input  wire logic                    fast_detect_b_in,
  input  wire logic                    lmfc_in,
  input  wire logic                    master_next_trigger_in,
  input  wire logic                    general_io_b_zero_in,
  output logic                         general_io_b_zero_out,
  output logic                         general_io_b_zero_oe,
  output logic                         general_io_b_zero_pulldown,
  output logic                         nco_chan_select,
  output logic                         slave_next_trigger_in
);
  import ctpc_pkg::*;

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic            xfer_q;        // Chip transfer bit
  logic            pd_dis_q;      // Local power-down pin disable
  logic [7:0]      pin_ctl1_q;    // Global pin mode and pin functions
  logic [7:0]      pin_ctl2_q;    // Secondary pin functions
  ctpc_xstate_type xstate_q;      // Transfer sequencer
  logic            copy_pulse;    // One-cycle master-to-slave load
  logic            xfer_req;      // Host or pin transfer request
  logic [2:0]      pd_sync_q;     // Power-down pin synchroniser
  logic [2:0]      bpin_sync_q;   // B pin input synchroniser
  logic            pd_lvl_q;      // Settled power-down pin level
  logic            bpin_lvl_q;    // Settled B pin level
  logic            bpin_prev_q;   // Previous settled B pin level
  logic            pin_active;    // Pin asserted and honoured
  ctpc_gpin_type   gpin;          // Global pin field
  ctpc_bfn_type    bfn;           // B pin function field
  ctpc_sec_type    bsec;          // B pin secondary field
  logic            wr_xfer;       // Host writes one to transfer bit
  logic            pin_rise;      // Settled B pin rising edge

  assign gpin = ctpc_gpin_type'(pin_ctl1_q[`CTPC_GPIN_HI:`CTPC_GPIN_LO]);
  assign bfn  = ctpc_bfn_type'(pin_ctl1_q[`CTPC_BFN_HI:`CTPC_BFN_LO]);
  assign bsec = ctpc_sec_type'(pin_ctl2_q[`CTPC_BSEC_HI:`CTPC_BSEC_LO]);
  assign pin_rise = bpin_lvl_q & ~bpin_prev_q;
  assign wr_xfer = reg_req.wr && (reg_req.addr == `CTPC_OFS_XFER)
                   && reg_req.wdata[`CTPC_XFER_BIT];

  // ----------------------------------------------------------------------
  // Host writes
  // ----------------------------------------------------------------------
  // Configuration registers; reserved bits never stored
  // reserved bits dropped
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pd_dis_q   <= 1'b0;
      pin_ctl1_q <= `CTPC_PIN_CTL1_RST;
      pin_ctl2_q <= `CTPC_PIN_CTL2_RST;
    end
    else if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        `CTPC_OFS_PD_GATE:  pd_dis_q   <= reg_req.wdata[`CTPC_PD_DIS_BIT];
        `CTPC_OFS_PIN_CTL1: pin_ctl1_q <= reg_req.wdata;
        `CTPC_OFS_PIN_CTL2: pin_ctl2_q <= reg_req.wdata;
        default:            pd_dis_q   <= pd_dis_q;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Host reads
  // ----------------------------------------------------------------------
  // Registered read data, zero for unmapped and reserved bits
  // reserved read zero
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd)
      begin
        unique case (reg_req.addr)
          `CTPC_OFS_XFER:     reg_rdata <= {7'h00, xfer_q};
          `CTPC_OFS_PD_GATE:  reg_rdata <= {pd_dis_q, 7'h00};
          `CTPC_OFS_PIN_CTL1: reg_rdata <= pin_ctl1_q;
          `CTPC_OFS_PIN_CTL2: reg_rdata <= pin_ctl2_q;
          default:            reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Chip transfer
  // ----------------------------------------------------------------------
  // Requests from host write or from B pin in transfer-input role
  // transfer input role
  assign xfer_req = wr_xfer
                    || (bfn == CTPC_BFN_SEC && bsec == CTPC_SEC_XFER && pin_rise);

  // Sequencer: request, then one copy cycle, then idle
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      xstate_q <= CTPC_XS_IDLE;
    end
    else
    begin
      unique case (xstate_q)
        CTPC_XS_IDLE: xstate_q <= xfer_req ? CTPC_XS_COPY : CTPC_XS_IDLE;
        CTPC_XS_COPY: xstate_q <= xfer_req ? CTPC_XS_COPY : CTPC_XS_IDLE;
      endcase
    end
  end

  assign copy_pulse = (xstate_q == CTPC_XS_COPY);

  // Self-clearing bit; a new request beats the clear
  // self clearing
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      xfer_q <= 1'b0;
    end
    else if (xfer_req)
    begin
      xfer_q <= 1'b1;
    end
    else if (copy_pulse)
    begin
      xfer_q <= 1'b0;
    end
  end

  ctpc_shadow #(.W(2 * `CTPC_PHASE_W)) u_phase (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (copy_pulse & phase_update_mode),
    .staged  (staged_phase),
    .active  (active_phase)
  );

  ctpc_shadow #(.W(`CTPC_COEF_W)) u_coef (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (copy_pulse),
    .staged  (staged_coef),
    .active  (active_coef)
  );

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pd_sync_q   <= 3'h0;
      bpin_sync_q <= 3'h0;
      pd_lvl_q    <= 1'b0;
      bpin_lvl_q  <= 1'b0;
      bpin_prev_q <= 1'b0;
    end
    else
    begin
      pd_sync_q   <= {pd_sync_q[1:0], powerdown_standby_pin};
      bpin_sync_q <= {bpin_sync_q[1:0], general_io_b_zero_in};
      if (pd_sync_q[1] == pd_sync_q[2])
      begin
        pd_lvl_q <= pd_sync_q[2];
      end
      if (bpin_sync_q[1] == bpin_sync_q[2])
      begin
        bpin_lvl_q <= bpin_sync_q[2];
      end
      bpin_prev_q <= bpin_lvl_q;
    end
  end

  // ----------------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------------
  // local disable gate
  assign pin_active = pd_lvl_q & ~pd_dis_q;

  // Pin overrides channel modes in 00 and 01; ignored otherwise
  // pin priority
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      chip_power_state <= CTPC_PWR_ON;
    end
    else if (pin_active && gpin == CTPC_GPIN_DOWN)
    begin
      chip_power_state <= CTPC_PWR_DOWN;
    end
    else if (pin_active && gpin == CTPC_GPIN_STBY)
    begin
      chip_power_state <= CTPC_PWR_STBY;
    end
    else
    begin
      chip_power_state <= chan_power_mode;
    end
  end

  // ----------------------------------------------------------------------
  // B pin function
  // ----------------------------------------------------------------------
  // Output value, enable and pull-down per function code
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      general_io_b_zero_out      <= 1'b0;
      general_io_b_zero_oe       <= 1'b0;
      general_io_b_zero_pulldown <= 1'b1;
    end
    else
    begin
      general_io_b_zero_out      <= 1'b0;
      general_io_b_zero_oe       <= 1'b0;
      general_io_b_zero_pulldown <= 1'b0;
      unique case (bfn)
        CTPC_BFN_FD:
        begin
          general_io_b_zero_out <= fast_detect_b_in;
          general_io_b_zero_oe  <= 1'b1;
        end
        CTPC_BFN_LMFC:
        begin
          general_io_b_zero_out <= lmfc_in;
          general_io_b_zero_oe  <= 1'b1;
        end
        CTPC_BFN_SEC:
        begin
          if (bsec == CTPC_SEC_TRIG_OUT)
          begin
            general_io_b_zero_out <= master_next_trigger_in;
            general_io_b_zero_oe  <= 1'b1;
          end
        end
        default: general_io_b_zero_pulldown <= 1'b1;
      endcase
    end
  end

  // Input roles: channel select level and trigger-in pulse
  // secondary inputs
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      nco_chan_select       <= 1'b0;
      slave_next_trigger_in <= 1'b0;
    end
    else
    begin
      if (bfn == CTPC_BFN_SEC && bsec == CTPC_SEC_GPI)
      begin
        nco_chan_select <= bpin_lvl_q;
      end
      slave_next_trigger_in <= (bfn == CTPC_BFN_SEC) && (bsec == CTPC_SEC_TRIG_IN)
                               && pin_rise;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_req;
    xfer_req;
  endsequence
  sequence s_copy_done;
    copy_pulse ##1 !xfer_q;
  endsequence

  chk_xfer_sets: assert property (@(posedge ref_clk) disable iff (rst)
    wr_xfer |=> xfer_q) else $error("transfer bit not set");
  chk_xfer_clears: assert property (@(posedge ref_clk) disable iff (rst)
    (s_req ##1 !xfer_req) |-> s_copy_done) else $error("transfer bit stuck");
  chk_coef_copy: assert property (@(posedge ref_clk) disable iff (rst)
    copy_pulse |=> active_coef == $past(staged_coef)) else $error("coef not copied");
  chk_phase_copy: assert property (@(posedge ref_clk) disable iff (rst)
    copy_pulse && phase_update_mode |=> active_phase == $past(staged_phase))
    else $error("phase not copied");
  chk_phase_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !copy_pulse |=> $stable(active_phase) && $stable(active_coef))
    else $error("active changed without transfer");
  chk_pin_down: assert property (@(posedge ref_clk) disable iff (rst)
    pd_lvl_q && !pd_dis_q && gpin == CTPC_GPIN_DOWN |=> chip_power_state == CTPC_PWR_DOWN)
    else $error("pin did not power down");
  chk_pin_stby: assert property (@(posedge ref_clk) disable iff (rst)
    pd_lvl_q && !pd_dis_q && gpin == CTPC_GPIN_STBY |=> chip_power_state == CTPC_PWR_STBY)
    else $error("pin did not enter standby");
  chk_pin_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    (pd_dis_q || gpin == CTPC_GPIN_OFF) |=> chip_power_state == $past(chan_power_mode))
    else $error("ignored pin changed power");
  chk_bpin_fd: assert property (@(posedge ref_clk) disable iff (rst)
    bfn == CTPC_BFN_FD |=> general_io_b_zero_oe
      && general_io_b_zero_out == $past(fast_detect_b_in))
    else $error("fast detect not driven");
  chk_bpin_off: assert property (@(posedge ref_clk) disable iff (rst)
    bfn == CTPC_BFN_OFF |=> !general_io_b_zero_oe && general_io_b_zero_pulldown)
    else $error("disabled pin driven");

endmodule

// [ctpc_host.sv]
// Host model: power-down pin driver and the shared B0 pin wire.
// Assumes the bench steers its inputs at ref_clk rising edges.
module ctpc_host (
  input  wire logic ref_clk,
  input  wire logic host_en,
  input  wire logic host_val,
  input  wire logic pd_req,
  input  wire logic dev_out,
  input  wire logic dev_oe,
  input  wire logic dev_pulldown,
  output logic      pin_lvl,
  output logic      pd_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  logic float_q = 1'b0; // Pattern shown by a released wire

  // ----------------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------------
  // Released wire without pull changes every cycle
  always @(posedge ref_clk)
    float_q <= ~float_q;

  always_comb
    if (dev_oe)
      pin_lvl = dev_out;
    else if (host_en)
      pin_lvl = host_val;
    else if (dev_pulldown)
      pin_lvl = 1'b0;
    else
      pin_lvl = float_q;

  assign pd_pin = pd_req; // Host holds the pin level
endmodule

// [ctpc_map.svh]
// Offsets, field positions, reset values and datapath widths of the control bank.
// Assumes includers compile it once; guarded against double inclusion.
`ifndef CTPC_MAP_SVH
`define CTPC_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CTPC_OFS_XFER      16'h000F
`define CTPC_OFS_PD_GATE   16'h003F
`define CTPC_OFS_PIN_CTL1  16'h0040
`define CTPC_OFS_PIN_CTL2  16'h0041

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTPC_XFER_BIT      0
`define CTPC_PD_DIS_BIT    7
`define CTPC_GPIN_HI       7
`define CTPC_GPIN_LO       6
`define CTPC_BFN_HI        5
`define CTPC_BFN_LO        3
`define CTPC_AFN_HI        2
`define CTPC_AFN_LO        0
`define CTPC_BSEC_HI       7
`define CTPC_BSEC_LO       4
`define CTPC_ASEC_HI       3
`define CTPC_ASEC_LO       0

// ----------------------------------------------------------------------
// Reset values and datapath widths
// ----------------------------------------------------------------------
`define CTPC_PIN_CTL1_RST  8'h3F
`define CTPC_PIN_CTL2_RST  8'h00
`define CTPC_PHASE_W       48
`define CTPC_COEF_W        16

`endif

// [ctpc_pkg.sv]
// Types shared by the chip transfer and pin control bank.
// Assumes ctpc_map.svh is on the include path.
package ctpc_pkg;

  // ----------------------------------------------------------------------
  // Register access carrier
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
    logic [15:0] addr;   // Register address
    logic [7:0]  wdata;  // Write data
  } ctpc_req_type;

  // Staged or active mixer phase pair
  typedef struct packed {
    logic [47:0] inc;    // Phase increment
    logic [47:0] off;    // Phase offset
  } ctpc_phase_type;

  // ----------------------------------------------------------------------
  // Codes and states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CTPC_GPIN_DOWN = 2'b00, CTPC_GPIN_STBY = 2'b01,
    CTPC_GPIN_OFF  = 2'b10, CTPC_GPIN_RSV  = 2'b11
  } ctpc_gpin_type;

  typedef enum logic [2:0] {
    CTPC_BFN_FD  = 3'b000, CTPC_BFN_LMFC = 3'b001,
    CTPC_BFN_SEC = 3'b110, CTPC_BFN_OFF  = 3'b111
  } ctpc_bfn_type;

  typedef enum logic [3:0] {
    CTPC_SEC_GPI  = 4'b0000, CTPC_SEC_XFER = 4'b0001,
    CTPC_SEC_TRIG_OUT = 4'b1000, CTPC_SEC_TRIG_IN = 4'b1001
  } ctpc_sec_type;

  typedef enum logic [1:0] {
    CTPC_PWR_ON = 2'b00, CTPC_PWR_STBY = 2'b01, CTPC_PWR_DOWN = 2'b10
  } ctpc_pwr_type;

  typedef enum logic [1:0] {
    CTPC_XS_IDLE = 2'b00, CTPC_XS_COPY = 2'b01
  } ctpc_xstate_type;

endpackage

// [ctpc_shadow.sv]
// Master-to-slave shadow register: the active copy takes the staged value
// on a one-cycle load pulse. Assumes the pulse is on ref_clk.
module ctpc_shadow #(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] staged,
  output logic      [W-1:0] active
);

  // Active copy, cleared by reset, loaded on pulse
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      active <= '0;
    end
    else if (load)
    begin
      active <= staged;
    end
  end

endmodule

// [tb_chip_transfer_pin_control.sv]
// Self-checking bench for the transfer and pin control bank.
// Assumes ctpc_pkg and ctpc_host are compiled before it.
module tb_chip_transfer_pin_control;
  import ctpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic           ref_clk   = 1'b0;
  logic           rst       = 1'b1;
  ctpc_req_type   req       = '0;
  logic [7:0]     rdata;
  logic           rvalid;
  logic           pd_req    = 1'b0;
  logic           pd_pin;
  ctpc_pwr_type   chan_mode = CTPC_PWR_ON;
  ctpc_pwr_type   pwr;
  logic           upd_mode  = 1'b0;
  ctpc_phase_type st_ph     = '0;
  ctpc_phase_type act_ph;
  ctpc_phase_type old_ph;
  logic [15:0]    st_cf     = 16'h0000;
  logic [15:0]    act_cf;
  logic           fast_b    = 1'b0;
  logic           lmfc      = 1'b0;
  logic           mnt       = 1'b0;
  logic           host_en   = 1'b0;
  logic           host_val  = 1'b0;
  logic           pin_lvl, b_out, b_oe, b_pd, nco_sel, slv_trig;
  integer         seed      = 14339;
  int             fail_count  = 0;
  int             comparisons = 0;
  int             n;
  logic [7:0]     exp_q[$]; // Expected read data, oldest first

  always #5 ref_clk = ~ref_clk;

  ctpc_bank uut (.ref_clk(ref_clk), .rst(rst), .reg_req(req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .powerdown_standby_pin(pd_pin), .chan_power_mode(chan_mode),
    .chip_power_state(pwr), .phase_update_mode(upd_mode), .staged_phase(st_ph),
    .active_phase(act_ph), .staged_coef(st_cf), .active_coef(act_cf),
    .fast_detect_b_in(fast_b), .lmfc_in(lmfc), .master_next_trigger_in(mnt),
    .general_io_b_zero_in(pin_lvl), .general_io_b_zero_out(b_out),
    .general_io_b_zero_oe(b_oe), .general_io_b_zero_pulldown(b_pd),
    .nco_chan_select(nco_sel), .slave_next_trigger_in(slv_trig));

  ctpc_host host (.ref_clk(ref_clk), .host_en(host_en), .host_val(host_val),
    .pd_req(pd_req), .dev_out(b_out), .dev_oe(b_oe), .dev_pulldown(b_pd),
    .pin_lvl(pin_lvl), .pd_pin(pd_pin));

  // ----------------------------------------------------------------------
  // Compare, report and bus tasks
  // ----------------------------------------------------------------------
  task automatic chk_rd(logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] read data expected %h seen %h", exp, got);
    end
  endtask

  task automatic chk_out(string name, logic [95:0] exp, logic [95:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cyc(int c);
    repeat (c) @(posedge ref_clk);
  endtask

  task automatic wr_reg(logic [15:0] a, logic [7:0] d);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    req <= '0;
  endtask

  task automatic rd_reg(logic [15:0] a, logic [7:0] e);
    @(posedge ref_clk);
    exp_q.push_back(e);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    req <= '0;
  endtask

  // Power state the pin and gates should give
  function automatic ctpc_pwr_type pwr_exp(logic g, logic [1:0] f, ctpc_pwr_type ch);
    if (g || f[1])
      return ch;
    return f[0] ? CTPC_PWR_STBY : CTPC_PWR_DOWN;
  endfunction

  // Read monitor: oldest note against each answer
  always @(posedge ref_clk)
    if (rvalid === 1'b1)
      chk_rd(exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rdata);

  // Watchdog well past the expected run length
  initial
  begin
    #100_000;
    fail_count++;
    give_verdict();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    cyc(4);
    rst <= 1'b0;
    rd_reg(16'h000F, 8'h00);
    rd_reg(16'h003F, 8'h00);
    rd_reg(16'h0040, 8'h3F);
    rd_reg(16'h0041, 8'h00);
    rd_reg(16'h0010, 8'h00);
    chk_out("b_pin", 2'b01, {b_oe, b_pd});
    // Reserved bits and a zero transfer write
    wr_reg(16'h003F, 8'hFF);
    rd_reg(16'h003F, 8'h80);
    st_cf <= 16'($random(seed));
    wr_reg(16'h000F, 8'hFE);
    rd_reg(16'h000F, 8'h00);
    chk_out("coef", 16'h0000, act_cf);
    // Transfer with and without phase update mode
    for (int m = 0; m < 2; m++)
    begin
      upd_mode <= m[0];
      st_ph <= {$random(seed), $random(seed), $random(seed)};
      st_cf <= 16'($random(seed));
      cyc(1);
      old_ph = act_ph;
      req <= '{1'b1, 1'b0, 16'h000F, 8'h01};
      @(posedge ref_clk);
      exp_q.push_back(8'h01);
      req <= '{1'b0, 1'b1, 16'h000F, 8'h00};
      @(posedge ref_clk);
      req <= '0;
      rd_reg(16'h000F, 8'h00);
      cyc(2);
      chk_out("coef", st_cf, act_cf);
      chk_out("phase", m ? st_ph : old_ph, act_ph);
    end
    // Pin gate, every global field code
    for (int k = 0; k < 8; k++)
    begin
      wr_reg(16'h003F, {k[2], 7'h00});
      wr_reg(16'h0040, {k[1:0], 6'h3F});
      chan_mode <= (k[1:0] == 2'b00) ? CTPC_PWR_STBY : CTPC_PWR_ON;
      pd_req <= 1'b1;
      cyc(6);
      chk_out("power", pwr_exp(k[2], k[1:0], chan_mode), pwr);
      pd_req <= 1'b0;
      cyc(6);
      chk_out("power", chan_mode, pwr);
    end
    // B pin function codes, including an unlisted one
    for (int r = 0; r < 8; r++)
    begin
      fast_b <= 1'($random(seed));
      lmfc <= 1'($random(seed));
      wr_reg(16'h0040, {2'b10, r[1:0] == 2'b11 ? 3'b011 : {1'b0, r[1:0]} | {3{r[1]}}, 3'b111});
      cyc(2);
      if (r[1:0] == 2'b00)
        chk_out("b_pin", {1'b1, fast_b, fast_b, 1'b0}, {b_oe, b_out, b_out, b_pd});
      else if (r[1:0] == 2'b01)
        chk_out("b_pin", {1'b1, lmfc, lmfc, 1'b0}, {b_oe, b_out, b_out, b_pd});
      else
        chk_out("b_pin", 2'b01, {b_oe, b_pd});
    end
    // Secondary field: next-trigger output
    mnt <= 1'($random(seed));
    wr_reg(16'h0040, 8'hB7);
    wr_reg(16'h0041, 8'h80);
    cyc(2);
    chk_out("b_pin", {1'b1, mnt}, {b_oe, b_out});
    // Secondary field: channel select input
    host_en <= 1'b1;
    host_val <= 1'b1;
    wr_reg(16'h0041, 8'h00);
    // Release, three sync stages, settled level, then the select register
    cyc(8);
    chk_out("nco_sel", 2'b01, {b_oe, nco_sel});
    host_val <= 1'b0;
    cyc(6);
    chk_out("nco_sel", 1'b0, nco_sel);
    // Secondary field: pin rise acts as transfer
    wr_reg(16'h0041, 8'h10);
    st_cf <= 16'($random(seed));
    cyc(2);
    host_val <= 1'b1;
    cyc(8);
    chk_out("coef", st_cf, act_cf);
    // Secondary field: slave trigger pulse
    host_val <= 1'b0;
    wr_reg(16'h0041, 8'h90);
    cyc(6);
    host_val <= 1'b1;
    n = 0;
    repeat (10)
    begin
      @(posedge ref_clk);
      n += int'(slv_trig === 1'b1);
    end
    chk_out("slave_trig", 1, n);
    // Unlisted secondary code drives nothing
    host_en <= 1'b0;
    wr_reg(16'h0041, 8'h50);
    cyc(2);
    chk_out("b_pin", 2'b00, {b_oe, b_pd});
    // Second reset brings defaults back
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    rd_reg(16'h0040, 8'h3F);
    cyc(4);
    // Every read asked for must have been answered
    chk_out("pending_reads", 96'h0, 96'(exp_q.size()));
    give_verdict();
  end
endmodule
